// >>> design/port_c_request_register.v
/*
 contents: port c pending-request register with apb slave, global
 enable, vectored request output and a sticky status interrupt.
 assumes: apb master on pclk; port c request pins are asynchronous.
*/
// Decided for this implementation: register access over APB.
// Functional notes
// RULE_01: request from source sets its pending bit
// RULE_02: global enable forwards pending requests to core
// RULE_03: pending bits stay readable while disabled
// RULE_04: bits 0-3 pins, 7-4 reserved, reset zero
// RULE_05: bit reads one while pin request waits
// RULE_06: software clears serviced request by writing zero
`timescale 1ns/1ps
`include "pcirq_defs.vh"

module port_c_request_register #(
   parameter pins = `PCIRQ_PIN_COUNT
)
(
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [13:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [pins-1:0] port_c_pin_request,
   output reg vectored_request,
   output reg [pins-1:0] vectored_pins,
   output reg irq
);

   // ===================================================================
   // pin edge capture
   wire [pins-1:0] req_rise;

   pin_request_sync #(
      .width(pins)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .pin(port_c_pin_request),
      .rise(req_rise)
   );

   // ===================================================================
   // registers and their next values
   reg [pins-1:0] port_c_pin_pending;
   reg global_enable;
   reg [1:0] status;
   reg [1:0] mask;
   reg [1:0] bus_state;
   wire [pins-1:0] next_pending;
   reg next_global_enable;
   reg [1:0] next_status;
   reg [1:0] next_mask;
   reg [1:0] next_bus_state;
   reg next_pready;
   reg next_pslverr;
   reg [31:0] next_prdata;
   reg next_vectored_request;
   reg [pins-1:0] next_vectored_pins;
   reg next_irq;

   // ===================================================================
   // constants
   localparam [7:0] rst_pending = `PCIRQ_RST_PENDING;
   localparam [7:0] rst_control = `PCIRQ_RST_CONTROL;
   localparam [7:0] rst_mask = `PCIRQ_RST_MASK;
   localparam [7:0] rst_status = `PCIRQ_RST_STATUS;
   localparam [13:0] addr_pending = `PCIRQ_ADDR_PENDING;
   localparam [13:0] addr_control = `PCIRQ_ADDR_CONTROL;
   localparam [13:0] addr_mask = `PCIRQ_ADDR_MASK;
   localparam [13:0] addr_status = `PCIRQ_ADDR_STATUS;
   localparam [1:0] bus_idle = 2'h0;
   localparam [1:0] bus_reply = 2'h1;

   // ===================================================================
   // apb handshake: one wait state
   // the access edge loads read data and raises pready; the next edge,
   // with pready high, completes the transfer and commits any write
   always @*
   begin
      next_bus_state = bus_state;
      case (bus_state)
         bus_idle:
         begin
            if (psel && penable)
            begin
               next_bus_state = bus_reply;
            end
         end
         bus_reply:
         begin
            next_bus_state = bus_idle;
         end
         default:
         begin
            next_bus_state = bus_idle;
         end
      endcase
   end

   wire access = psel & penable & ce & (bus_state == bus_idle);
   wire complete = psel & penable & ce & (bus_state == bus_reply);
   wire wr = complete & pwrite;
   wire rd = access & ~pwrite;
   wire hit_pend = (paddr == addr_pending);
   wire hit_ctrl = (paddr == addr_control);
   wire hit_mask = (paddr == addr_mask);
   wire hit_stat = (paddr == addr_status);
   wire hit_any = hit_pend | hit_ctrl | hit_mask | hit_stat;
   wire wr_pend = wr & hit_pend;
   wire wr_ctrl = wr & hit_ctrl;
   wire wr_mask = wr & hit_mask;
   wire rd_stat = rd & hit_stat;

   always @*
   begin
      next_pready = 1'h0;
      next_pslverr = 1'h0;
      if (next_bus_state == bus_reply)
      begin
         next_pready = 1'h1;
         next_pslverr = ~hit_any;
      end
   end

   // ===================================================================
   // pending bits: a request edge wins over a clear in the same cycle,
   // so a request arriving while software clears is never lost
   genvar i;
   generate
      for (i = 0; i < pins; i = i + 1)
      begin : g_pend
         wire held;
         assign held = wr_pend ? pwdata[i] : port_c_pin_pending[i];
         assign next_pending[i] = req_rise[i] | held; // [RULE_01]
      end
   endgenerate

   // ===================================================================
   // control and mask
   always @*
   begin
      next_global_enable = global_enable;
      if (wr_ctrl)
      begin
         next_global_enable = pwdata[`PCIRQ_CTRL_GIE];
      end
   end

   always @*
   begin
      next_mask = mask;
      if (wr_mask)
      begin
         next_mask = pwdata[1:0];
      end
   end

   // ===================================================================
   // status events: a request edge, and forwarding newly raised
   wire ev_req = |req_rise;
   wire ev_vec = global_enable & |next_pending & ~vectored_request;

   always @*
   begin
      next_status = status;
      if (rd_stat)
      begin
         next_status = 2'h0;
      end
      // set wins over the read clear
      if (ev_req)
      begin
         next_status[`PCIRQ_STAT_REQ] = 1'h1;
      end
      if (ev_vec)
      begin
         next_status[`PCIRQ_STAT_VEC] = 1'h1;
      end
   end

   always @*
   begin
      next_irq = |(next_status & mask);
   end

   // ===================================================================
   // forwarding to the core
   // disabled: nothing is forwarded and software polls instead
   always @*
   begin
      next_vectored_request = 1'h0;
      next_vectored_pins = {pins{1'h0}};
      if (global_enable)
      begin
         next_vectored_request = |next_pending; // [RULE_02]
         next_vectored_pins = next_pending;
      end
   end

   // ===================================================================
   // read mux: reserved bits and unmapped addresses read zero
   always @*
   begin
      next_prdata = 32'h00000000; // [RULE_04]
      if (rd)
      begin
         if (hit_pend)
         begin
            next_prdata[pins-1:0] = port_c_pin_pending; // [RULE_03] [RULE_05]
         end
         if (hit_ctrl)
         begin
            next_prdata[`PCIRQ_CTRL_GIE] = global_enable;
         end
         if (hit_mask)
         begin
            next_prdata[1:0] = mask;
         end
         if (hit_stat)
         begin
            next_prdata[1:0] = status;
         end
      end
   end

   // ===================================================================
   // state: every flop holds while ce is low
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_c_pin_pending <= rst_pending[pins-1:0]; // [RULE_04]
      end
      else if (ce)
      begin
         port_c_pin_pending <= next_pending;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         global_enable <= rst_control[`PCIRQ_CTRL_GIE];
      end
      else if (ce)
      begin
         global_enable <= next_global_enable;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask <= rst_mask[1:0];
      end
      else if (ce)
      begin
         mask <= next_mask;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status <= rst_status[1:0];
      end
      else if (ce)
      begin
         status <= next_status;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_state <= bus_idle;
      end
      else if (ce)
      begin
         bus_state <= next_bus_state;
      end
   end

   // ===================================================================
   // outputs, each straight from a flop
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'h0;
         pslverr <= 1'h0;
         vectored_request <= 1'h0;
         vectored_pins <= {pins{1'h0}};
         irq <= 1'h0;
      end
      else if (ce)
      begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         vectored_request <= next_vectored_request;
         vectored_pins <= next_vectored_pins;
         irq <= next_irq;
      end
   end

endmodule // port_c_request_register

// >>> design/pcirq_defs.vh
/*
 contents: offsets, field positions, reset values and widths for the
 port c pending-request block.
 assumes: included by bare name from the design files under design/.
*/
`ifndef PCIRQ_DEFS_VH
`define PCIRQ_DEFS_VH

// ===================================================================
// register index and byte addresses (apb, one aligned word each)
// the pending register is word index FC6: its byte address is four times it
`define PCIRQ_IDX_PENDING 12'hFC6
`define PCIRQ_ADDR_PENDING {`PCIRQ_IDX_PENDING, 2'h0}
`define PCIRQ_ADDR_CONTROL 14'h0FC8
`define PCIRQ_ADDR_MASK 14'h0FCC
`define PCIRQ_ADDR_STATUS 14'h0FD0

// ===================================================================
// field layout
`define PCIRQ_PIN_COUNT 4
`define PCIRQ_REG_WIDTH 8
`define PCIRQ_CTRL_GIE 0
`define PCIRQ_STAT_REQ 0
`define PCIRQ_STAT_VEC 1

// ===================================================================
// reset values
`define PCIRQ_RST_PENDING 8'h00
`define PCIRQ_RST_CONTROL 8'h00
`define PCIRQ_RST_MASK 8'h00
`define PCIRQ_RST_STATUS 8'h00

`endif

// >>> design/pin_request_sync.v
/*
 contents: two-flop synchroniser and rising-edge detector per pin.
 assumes: pins are asynchronous to pclk; pulse is one pclk cycle wide.
*/
`timescale 1ns/1ps
`include "pcirq_defs.vh"

module pin_request_sync #(
   parameter width = `PCIRQ_PIN_COUNT
)
(
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire [width-1:0] pin,
   output wire [width-1:0] rise
);

   // ===================================================================
   // synchroniser chain
   reg [width-1:0] meta;
   reg [width-1:0] sync;
   reg [width-1:0] last;

   // first stage feeds only the second stage
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta <= {width{1'b0}};
         sync <= {width{1'b0}};
         last <= {width{1'b0}};
      end
      else if (ce)
      begin
         meta <= pin;
         sync <= meta;
         last <= sync;
      end
   end

   assign rise = sync & ~last & {width{ce}};

endmodule // pin_request_sync

// >>> bench/pcirq_props.sv
/* checker of the pending-request block
 assumes: bound to port_c_request_register, ce low only while disabled */
`timescale 1ns/1ps
`include "pcirq_defs.vh"
module pcirq_props(
   input wire pclk,
   input wire presetn,
   input wire pwrite,
   input wire [13:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [3:0] port_c_pin_request,
   input wire vectored_request,
   input wire [3:0] vectored_pins
);
   // ===
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence rd_pend;
      pready && !pwrite && paddr == `PCIRQ_ADDR_PENDING;
   endsequence
   pin_sets_a: assert property (
      $rose(port_c_pin_request[0]) && vectored_request
      |-> ##[1:6] vectored_pins[0]) else $error("pin lost");
   core_fwd_a: assert property (
      vectored_request == (vectored_pins != 4'h0)) else $error("fwd");
   poll_ok_a: assert property (rd_pend |-> !pslverr)
      else $error("poll");
   rsvd_zero_a: assert property (
      rd_pend |-> prdata[31:4] == 28'h0) else $error("rsvd");
   bit_shown_a: assert property (
      rd_pend ##0 $past(vectored_request)
      |-> prdata[3:0] == $past(vectored_pins)) else $error("bit");
endmodule // pcirq_props
bind port_c_request_register pcirq_props pcirq_props_inst(
   .pclk(pclk),
   .presetn(presetn),
   .pwrite(pwrite),
   .paddr(paddr),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .port_c_pin_request(port_c_pin_request),
   .vectored_request(vectored_request),
   .vectored_pins(vectored_pins)
);

// >>> bench/core_model.sv
/* core model: takes vectored requests
 assumes: same clock as the block */
`timescale 1ns/1ps
module core_model(
   input wire pclk,
   input wire presetn,
   input wire vectored_request,
   input wire [3:0] vectored_pins,
   output logic [3:0] taken
);
   // ===
   // log only, never clears: a lost vector shows at the end
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         taken <= 4'h0;
      else if (vectored_request)
         taken <= taken | vectored_pins;
endmodule // core_model

// >>> bench/port_c_request_register_tb.sv
/* bench: apb master, pins, core model
 assumes: pcirq_defs.vh on the include path */
`timescale 1ns/1ps
`include "pcirq_defs.vh"
module port_c_request_register_tb;
   // ===
   // stimulus
   localparam [13:0] pa = `PCIRQ_ADDR_PENDING;
   logic pclk = 1'h0, presetn = 1'h0, ce = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [3:0] port_c_pin_request = 4'h0;
   logic [7:0] seed = 8'h30;
   wire [31:0] prdata;
   wire [3:0] vectored_pins, taken;
   wire pready, pslverr, vectored_request, irq;
   int miscompares = 0, n_compared = 0, cyc = 0;
   port_c_request_register port_c_request_register_inst(
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .port_c_pin_request(port_c_pin_request),
      .vectored_request(vectored_request),
      .vectored_pins(vectored_pins),
      .irq(irq)
   );
   core_model core_model_inst(
      .pclk(pclk),
      .presetn(presetn),
      .vectored_request(vectored_request),
      .vectored_pins(vectored_pins),
      .taken(taken)
   );
   function [7:0] lfsr(input [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function [31:0] pend(input [7:0] v);
      return {28'h0, v[3:0]};
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %0t %h %h", $time, got, exp);
      end
   endtask
   task test_done;
      miscompares += (cyc >= 2000);
      $display("compared %0d wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // error flag folded into bit 31: unmapped reads return 80000000 in rd
   task apb(input w, input [13:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
         @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata ^ {pslverr, 31'h0};
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task hold(input [3:0] p);
      port_c_pin_request <= p;
      repeat (8) @(posedge pclk);
   endtask
   initial forever #2.5 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cyc = cyc + 1;
      if (cyc == 2000)
         test_done;
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, pa, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, 14'h0000, 32'h0);
      chk(rd, 32'h80000000);
      apb(1'h1, `PCIRQ_ADDR_MASK, 32'h1);
      apb(1'h1, `PCIRQ_ADDR_CONTROL, 32'h1);
      hold(4'h2);
      hold(4'h3);
      chk({31'h0, irq}, 32'h1);
      apb(1'h0, `PCIRQ_ADDR_STATUS, 32'h0);
      chk(rd, 32'h3);
      hold(4'h3);
      chk({31'h0, irq}, 32'h0);
      chk({28'h0, taken}, 32'h3);
      repeat (4)
      begin
         apb(1'h1, pa, 32'h0);
         hold(4'h0);
         seed = lfsr(seed);
         hold(seed[3:0]);
         apb(1'h0, pa, 32'h0);
         chk(rd, pend(seed));
      end
      apb(1'h1, `PCIRQ_ADDR_CONTROL, 32'h0);
      hold(4'hF);
      apb(1'h0, pa, 32'h0);
      chk(rd | {27'h0, vectored_request, 4'h0}, 32'hF);
      apb(1'h1, pa, 32'hF5);
      apb(1'h0, pa, 32'h0);
      chk(rd, 32'h5);
      // frozen while ce is low: the pin dip must not raise requests
      ce <= 1'h0;
      hold(4'h0);
      hold(4'hA);
      ce <= 1'h1;
      hold(4'hA);
      apb(1'h0, pa, 32'h0);
      chk(rd, 32'h5);
      test_done;
   end
endmodule // port_c_request_register_tb
